// file: shared/pcmdec_pkg.sv
// Notes on behaviour
// - Serial stream is deserialised into eight-bit words shown in parallel.
// - Line is sampled mid-bit from recovered timing; a clean bit is regenerated.
// - Bits shift through a register; sync pattern search gives frame lock.
// - Every data word of a locked frame goes out with its mapped address and a read strobe; sync slots do not.
// - The word path toward the computer carries data only, no address.
// - Address plus data form a 21-line bus copied to store and consoles.
// - Event store accepts words whose address falls in its 150-word range; only the base address EVT_BASE is configured.
// - Event store holds 150 words of eight bits, loaded when the bus copy is taken from the buffer.
// - Each stored event bit is a continuous status output.
// - Console decodes address; on match data goes into the D/A holding register.
// - Each console has its own static address configuration.
// - A console may choose among four addresses by a panel selector.
// - Serial bit rates up to 1 Mbit/s are accepted.
package pcmdec_pkg;
    localparam int WORD_W = 8;
    localparam int ADDR_W = 13;
    localparam int BUS_W = 21;
    localparam int MAP_W = 8;
    localparam int MAP_DEPTH = 256;
    localparam int EVT_WORDS = 150;
    localparam int EVT_IDX_W = 8;
    localparam int N_CONSOLE = 4;
    localparam int N_CAND = 4;
    localparam int SYNC_W = 24;
    localparam int SYNC_WORDS = SYNC_W / WORD_W;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_MHZ = 125;
    localparam int MAX_RATE_KBPS = 1000;
    // Shortest bit period in cycles at the top rate; rate counter must span more
    localparam int MIN_BIT_CYC = (CLK_MHZ * 1000) / MAX_RATE_KBPS;
    localparam int BITCNT_W = 16;
    localparam logic [2:0] WORD_BITS_LAST = 3'h7;
    localparam logic [MAP_W-1:0] WORD_IDX_RST = 8'h00;
    localparam logic [BITCNT_W-1:0] BITCNT_RST = 16'h0000;
    localparam logic [SYNC_W-1:0] SYNC_RST = 24'h000000;
    typedef enum logic [1:0]
    {
        PD_HUNT = 2'b00,
        PD_LOCK = 2'b01
    } pcmdec_state_e;
endpackage

// file: src/pcmdec_fifo.sv
`timescale 1ns/100ps
module pcmdec_fifo
#(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [PW:0] count, next_count;
    logic push, pop;

    ////////////////////////////////////////////////////////////////
    // Honest full and empty from an occupancy count
    always_comb
    begin
        in_ready = (count != DEPTH[PW:0]);
        out_valid = (count != '0);
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // Storage is not reset; only entries below count are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign out_data = mem[rd_ptr];
endmodule

// file: src/pcmdec_top.sv
`timescale 1ns/100ps
module pcmdec_top
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Serial telemetry line
    input wire logic PCM_IN,
    // Static configuration
    input wire logic [pcmdec_pkg::BITCNT_W-1:0] BIT_PERIOD,
    input wire logic [pcmdec_pkg::SYNC_W-1:0] SYNC_PATTERN,
    input wire logic [pcmdec_pkg::MAP_W-1:0] FRAME_WORDS,
    input wire logic MAP_WE,
    input wire logic [pcmdec_pkg::MAP_W-1:0] MAP_WADDR,
    input wire logic [pcmdec_pkg::ADDR_W-1:0] MAP_WDATA,
    input wire logic [pcmdec_pkg::ADDR_W-1:0] EVT_BASE,
    input wire logic [pcmdec_pkg::N_CONSOLE*pcmdec_pkg::N_CAND*pcmdec_pkg::ADDR_W-1:0] CON_ADDR,
    input wire logic [pcmdec_pkg::N_CONSOLE*2-1:0] CON_SEL,
    // Data-only word path
    output logic [pcmdec_pkg::WORD_W-1:0] CPU_DATA,
    output logic CPU_STB,
    // Distribution bus copy out of the buffer
    output logic [pcmdec_pkg::BUS_W-1:0] DIST_BUS,
    output logic DIST_STB,
    input wire logic DIST_READY,
    output logic DIST_OVERRUN,
    // Status
    output logic FRAME_LOCK,
    output logic [pcmdec_pkg::EVT_WORDS*pcmdec_pkg::WORD_W-1:0] EVENT_STATUS,
    output logic [pcmdec_pkg::N_CONSOLE*pcmdec_pkg::WORD_W-1:0] CON_DAC
);
    import pcmdec_pkg::*;

    logic [BITCNT_W-1:0] bit_cnt, next_bit_cnt;
    logic line_q, next_line_q;
    logic bit_stb;
    logic clean_bit, next_clean_bit;
    logic [SYNC_W-1:0] shreg, next_shreg;
    pcmdec_state_e state, next_state;
    logic [2:0] bit_in_word, next_bit_in_word;
    logic [MAP_W-1:0] word_idx, next_word_idx;
    logic word_done;
    logic word_end;
    logic [ADDR_W-1:0] word_map [MAP_DEPTH];
    logic [WORD_W-1:0] out_data, next_out_data;
    logic [ADDR_W-1:0] out_addr, next_out_addr;
    logic out_stb, next_out_stb;
    logic overrun, next_overrun;
    logic fifo_in_ready;
    logic [BUS_W-1:0] fifo_out;
    logic fifo_valid;
    logic dist_pop;
    logic [EVT_WORDS*WORD_W-1:0] events, next_events;
    logic [N_CONSOLE*WORD_W-1:0] dac, next_dac;

    ////////////////////////////////////////////////////////////////
    // Bit timing: resync on every line edge, sample half a bit later
    always_comb
    begin
        next_line_q = PCM_IN;
        bit_stb = 1'b0;
        next_clean_bit = clean_bit;
        if (line_q != PCM_IN)
        begin
            next_bit_cnt = BITCNT_RST;
        end
        else if (bit_cnt == BIT_PERIOD - 1'b1)
        begin
            next_bit_cnt = BITCNT_RST;
        end
        else
        begin
            next_bit_cnt = bit_cnt + 1'b1;
        end
        // Mid-bit sample avoids edge jitter; BIT_PERIOD >= MIN_BIT_CYC covers 1 Mbit/s
        if (bit_cnt == (BIT_PERIOD >> 1))
        begin
            bit_stb = 1'b1;
            next_clean_bit = line_q;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bit_cnt <= BITCNT_RST;
            line_q <= 1'b0;
            clean_bit <= 1'b0;
        end
        else
        begin
            bit_cnt <= next_bit_cnt;
            line_q <= next_line_q;
            clean_bit <= next_clean_bit;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Shift register and frame lock
    logic bit_stb_q;
    logic sync_hit;
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bit_stb_q <= 1'b0;
        end
        else
        begin
            bit_stb_q <= bit_stb;
        end
    end

    always_comb
    begin
        next_shreg = bit_stb_q ? {shreg[SYNC_W-2:0], clean_bit} : shreg;
        sync_hit = bit_stb_q && ({shreg[SYNC_W-2:0], clean_bit} == SYNC_PATTERN);
        next_state = state;
        next_bit_in_word = bit_in_word;
        next_word_idx = word_idx;
        word_done = 1'b0;
        word_end = 1'b0;
        case (state)
            PD_HUNT:
            begin
                if (sync_hit)
                begin
                    next_state = PD_LOCK;
                    next_bit_in_word = 3'h0;
                    next_word_idx = MAP_W'(SYNC_WORDS);
                end
            end
            PD_LOCK:
            begin
                if (bit_stb_q)
                begin
                    next_bit_in_word = bit_in_word + 3'h1;
                    if (bit_in_word == WORD_BITS_LAST)
                    begin
                        word_end = 1'b1;
                        // Sync slots keep the count aligned but are never sent out
                        word_done = (word_idx >= MAP_W'(SYNC_WORDS));
                        if (word_idx == FRAME_WORDS - 1'b1)
                        begin
                            next_word_idx = WORD_IDX_RST;
                        end
                        else
                        begin
                            next_word_idx = word_idx + 1'b1;
                        end
                    end
                end
                // Sync must fill the sync slots after every wrap, else hunt again
                if (word_end && word_idx == MAP_W'(SYNC_WORDS - 1) && !sync_hit)
                begin
                    next_state = PD_HUNT;
                end
            end
            default:
            begin
                next_state = PD_HUNT;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            shreg <= SYNC_RST;
            state <= PD_HUNT;
            bit_in_word <= 3'h0;
            word_idx <= WORD_IDX_RST;
        end
        else
        begin
            shreg <= next_shreg;
            state <= next_state;
            bit_in_word <= next_bit_in_word;
            word_idx <= next_word_idx;
        end
    end

    assign FRAME_LOCK = (state == PD_LOCK);

    // Word map is loadable storage, written from the configuration port
    always_ff @(posedge CLK)
    begin
        if (MAP_WE)
        begin
            word_map[MAP_WADDR] <= MAP_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Parallel word, mapped address and one-cycle read strobe
    always_comb
    begin
        next_out_data = out_data;
        next_out_addr = out_addr;
        next_out_stb = 1'b0;
        next_overrun = overrun;
        if (word_done)
        begin
            next_out_data = next_shreg[WORD_W-1:0];
            next_out_addr = word_map[word_idx];
            next_out_stb = 1'b1;
            if (!fifo_in_ready)
            begin
                next_overrun = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            out_data <= '0;
            out_addr <= '0;
            out_stb <= 1'b0;
            overrun <= 1'b0;
        end
        else
        begin
            out_data <= next_out_data;
            out_addr <= next_out_addr;
            out_stb <= next_out_stb;
            overrun <= next_overrun;
        end
    end

    assign CPU_DATA = out_data;
    assign CPU_STB = out_stb;
    assign DIST_OVERRUN = overrun;

    ////////////////////////////////////////////////////////////////
    // Buffer absorbs stalls on the external bus copy
    pcmdec_fifo #(.WIDTH(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(CLK),
        .rst_n(RST_N),
        .in_valid(out_stb),
        .in_ready(fifo_in_ready),
        .in_data({out_addr, out_data}),
        .out_valid(fifo_valid),
        .out_ready(DIST_READY),
        .out_data(fifo_out)
    );

    assign DIST_BUS = fifo_out;
    assign DIST_STB = fifo_valid;
    assign dist_pop = fifo_valid && DIST_READY;

    ////////////////////////////////////////////////////////////////
    // Event store and console selectors, fed from the bus copy
    logic [ADDR_W-1:0] bus_addr;
    logic [WORD_W-1:0] bus_data;
    logic [ADDR_W-1:0] evt_off;
    assign bus_addr = fifo_out[BUS_W-1:WORD_W];
    assign bus_data = fifo_out[WORD_W-1:0];
    assign evt_off = bus_addr - EVT_BASE;

    always_comb
    begin
        next_events = events;
        next_dac = dac;
        if (dist_pop && bus_addr >= EVT_BASE && evt_off < ADDR_W'(EVT_WORDS))
        begin
            next_events[evt_off[EVT_IDX_W-1:0]*WORD_W +: WORD_W] = bus_data;
        end
        for (int c = 0; c < N_CONSOLE; c++)
        begin
            // Panel selector picks one of four candidate addresses per console
            if (dist_pop && bus_addr == CON_ADDR[(c*N_CAND + CON_SEL[c*2 +: 2])*ADDR_W +: ADDR_W])
            begin
                next_dac[c*WORD_W +: WORD_W] = bus_data;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            events <= '0;
            dac <= '0;
        end
        else
        begin
            events <= next_events;
            dac <= next_dac;
        end
    end

    assign EVENT_STATUS = events;
    assign CON_DAC = dac;

    ////////////////////////////////////////////////////////////////
    // Checks
    sequence s_word_end;
        word_done && FRAME_LOCK;
    endsequence

    a_strobe_one_cycle: assert property (@(posedge CLK) disable iff (!RST_N)
        out_stb |=> !out_stb)
        else $error("read strobe longer than one cycle");
    a_strobe_from_word: assert property (@(posedge CLK) disable iff (!RST_N)
        s_word_end |=> out_stb && out_addr == $past(word_map[word_idx]))
        else $error("word strobe or address wrong");
    a_data_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        out_stb |-> CPU_DATA == shreg[WORD_W-1:0])
        else $error("word data not from shift register");
    a_lock_on_sync: assert property (@(posedge CLK) disable iff (!RST_N)
        (state == PD_HUNT && sync_hit) |=> FRAME_LOCK)
        else $error("no lock after sync");
    a_bus_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        (DIST_STB && !DIST_READY) |=> DIST_STB && $stable(DIST_BUS))
        else $error("bus changed while stalled");
    a_event_load: assert property (@(posedge CLK) disable iff (!RST_N)
        (dist_pop && bus_addr == EVT_BASE) |=> EVENT_STATUS[WORD_W-1:0] == $past(bus_data))
        else $error("event word not stored");
    a_event_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        !dist_pop |=> $stable(EVENT_STATUS))
        else $error("event status changed without strobe");
    a_console_load: assert property (@(posedge CLK) disable iff (!RST_N)
        (dist_pop && CON_SEL[3:2] == 2'h1 && bus_addr == CON_ADDR[5*ADDR_W +: ADDR_W])
        |=> CON_DAC[2*WORD_W-1:WORD_W] == $past(bus_data))
        else $error("console holding register not loaded");
    a_bit_sample: assert property (@(posedge CLK) disable iff (!RST_N)
        bit_stb |=> clean_bit == $past(line_q))
        else $error("bit not regenerated at sample point");
endmodule

// file: testbench/pcmdec_src.sv
`timescale 1ns/100ps
module pcmdec_src
(
    // Clock
    input wire logic clk,
    // Bit timing
    input wire logic [15:0] bit_period,
    // Serial line
    output logic pcm_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // NRZ line has no released state, so it simply holds the last bit level
    initial
    begin
        pcm_out = 1'b0;
    end

    // Sends n bits of v, MSB first, each held for one full bit period
    task automatic send_bits(input logic [23:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            @(negedge clk);
            pcm_out = v[i];
            repeat (bit_period - 1) @(negedge clk);
        end
    endtask
endmodule

// file: testbench/test_pcm_decommutator_event_analog_dist.sv
`timescale 1ns/100ps
module test_pcm_decommutator_event_analog_dist;
    import pcmdec_pkg::*;
    logic CLK = 0, RST_N = 0, PCM_IN, MAP_WE = 0, DIST_READY = 0;
    logic [15:0] BIT_PERIOD = 16'h0008;
    logic [23:0] SYNC_PATTERN = 24'he2f1a5;
    logic [7:0] FRAME_WORDS = 8'h06, MAP_WADDR = 8'h00, CON_SEL = 8'h00, CPU_DATA, cexp;
    logic [12:0] MAP_WDATA = 13'h0000, EVT_BASE = 13'h0100, a;
    logic [207:0] CON_ADDR;
    logic CPU_STB, DIST_STB, DIST_OVERRUN, FRAME_LOCK;
    logic [20:0] DIST_BUS, e;
    logic [1199:0] EVENT_STATUS, evt_m = '0;
    logic [31:0] CON_DAC, dac_m = '0;
    logic [12:0] map_m [8];
    logic [7:0] cpu_q [$];
    logic [20:0] dist_q [$];
    integer seed = 32'h989be939;
    int errors = 0, n_checks = 0, nstb = 0, snap;
    bit ign_c = 0, ign_d = 0, rdy_en = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // 8 ns clock
    always #4 CLK = ~CLK;

    pcmdec_src src (.clk(CLK), .bit_period(BIT_PERIOD), .pcm_out(PCM_IN));

    pcmdec_top DUT (.CLK(CLK), .RST_N(RST_N), .PCM_IN(PCM_IN), .BIT_PERIOD(BIT_PERIOD),
        .SYNC_PATTERN(SYNC_PATTERN), .FRAME_WORDS(FRAME_WORDS), .MAP_WE(MAP_WE),
        .MAP_WADDR(MAP_WADDR), .MAP_WDATA(MAP_WDATA), .EVT_BASE(EVT_BASE),
        .CON_ADDR(CON_ADDR), .CON_SEL(CON_SEL), .CPU_DATA(CPU_DATA), .CPU_STB(CPU_STB),
        .DIST_BUS(DIST_BUS), .DIST_STB(DIST_STB), .DIST_READY(DIST_READY),
        .DIST_OVERRUN(DIST_OVERRUN), .FRAME_LOCK(FRAME_LOCK), .EVENT_STATUS(EVENT_STATUS),
        .CON_DAC(CON_DAC));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [20:0] got, input logic [20:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_state(input logic [1199:0] got, input logic [1199:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t stored state differs from model", $time);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic map_wr(input logic [7:0] idx, input logic [12:0] adr);
        @(negedge CLK);
        MAP_WE = 1;
        MAP_WADDR = idx;
        MAP_WDATA = adr;
        map_m[idx] = adr;
        @(negedge CLK);
        MAP_WE = 0;
    endtask

    // One frame: sync then three data words; good frames note expected words
    task automatic send_frame(input bit good, input int slot);
        logic [7:0] d [3];
        map_wr(8'h03, EVT_BASE + 13'(slot));
        for (int i = 0; i < 3; i++)
        begin
            d[i] = good ? 8'($random(seed)) : 8'h00;
            if (good)
            begin
                cpu_q.push_back(d[i]);
                dist_q.push_back({map_m[i + 3], d[i]});
            end
        end
        src.send_bits(good ? SYNC_PATTERN : ~SYNC_PATTERN, 24);
        for (int i = 0; i < 3; i++)
            src.send_bits({16'h0000, d[i]}, 8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Random drain stalls hold some words in the buffer for extra cycles during normal traffic
    always @(negedge CLK)
        DIST_READY <= rdy_en && (($random(seed) & 3) != 0);

    // Computer path carries data only, in stream order
    always @(posedge CLK)
    begin
        if (RST_N && CPU_STB)
        begin
            nstb++;
            if (!ign_c)
            begin
                cexp = cpu_q.size() != 0 ? cpu_q.pop_front() : 'x;
                chk_word({13'h0, CPU_DATA}, {13'h0, cexp});
            end
        end
    end

    // Bus copy checked on each pop; stores compared half a cycle later
    always @(posedge CLK)
    begin
        if (RST_N && DIST_STB && DIST_READY && !ign_d)
        begin
            e = dist_q.size() != 0 ? dist_q.pop_front() : 'x;
            chk_word(DIST_BUS, e);
            a = e[20:8];
            if (a >= EVT_BASE && a - EVT_BASE < EVT_WORDS)
                evt_m[(a - EVT_BASE) * 8 +: 8] = e[7:0];
            for (int c = 0; c < 4; c++)
                if (a == CON_ADDR[(c * 4 + CON_SEL[c * 2 +: 2]) * 13 +: 13])
                    dac_m[c * 8 +: 8] = e[7:0];
            @(negedge CLK);
            chk_state(EVENT_STATUS, evt_m);
            chk_state({1168'h0, CON_DAC}, {1168'h0, dac_m});
        end
    end

    // Watchdog, well beyond the roughly 5000 cycles the sequence needs
    initial
    begin
        #200000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        // Console c candidate k answers to 0x800 + 16c + k, clear of event range
        for (int i = 0; i < 16; i++)
            CON_ADDR[i * 13 +: 13] = 13'h0800 + 13'((i / 4) * 16 + i % 4);
        repeat (12) @(posedge CLK);
        @(negedge CLK);
        RST_N = 1;
        chk_word({20'h0, FRAME_LOCK}, 21'h0);
        map_wr(8'h04, 13'h0810);
        map_wr(8'h05, 13'h1fff);
        // Event slots at both ends of the store, then random ones
        for (int f = 0; f < 4; f++)
            send_frame(1, f == 0 ? 0 : f == 1 ? 149 : ($random(seed) & 32'h7fff) % 150);
        chk_word({20'h0, FRAME_LOCK}, 21'h1);
        // Every panel selector position on console 1
        for (int k = 0; k < 4; k++)
        begin
            map_wr(8'h04, 13'h0810 + 13'(k));
            @(negedge CLK);
            CON_SEL[3:2] = 2'(k);
            send_frame(1, ($random(seed) & 32'h7fff) % 150);
        end
        for (int i = 0; i < 2000 && dist_q.size() != 0; i++)
            @(negedge CLK);
        chk_word({20'h0, DIST_OVERRUN}, 21'h0);
        // Hold the drain side off until more than eight words have arrived
        ign_d = 1;
        rdy_en = 0;
        repeat (3) send_frame(1, 7);
        chk_word({19'h0, DIST_OVERRUN, DIST_STB}, 21'h3);
        // Broken sync drops lock and nothing is emitted while hunting
        ign_c = 1;
        send_frame(0, 7);
        chk_word({20'h0, FRAME_LOCK}, 21'h0);
        snap = nstb;
        send_frame(0, 7);
        chk_word(21'(nstb), 21'(snap));
        end_sim();
    end
endmodule
